// ===== dv/cfg_regs_sva.sv
`timescale 1ns/10ps
module cfg_regs_sva (
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_rd,
	input wire logic        reg_rvalid,
	input wire logic        loop_zero_active,
	input wire logic        loop_one_active,
	input wire logic        loop_code_reserved,
	input wire logic [3:0]  phase_acq_enable,
	input wire logic [15:0] synth_a_base_rate_hz,
	input wire logic [15:0] synth_a_rate_multiplier,
	input wire logic [15:0] fec_numerator,
	input wire logic [15:0] fec_denominator
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// a write to the loop byte, not overwritten in the next cycle
	sequence s_cfg;
		reg_wr && reg_addr == 8'h4f ##1 !(reg_wr && reg_addr == 8'h4f);
	endsequence
	a_loop_none: assert property (reg_wdata[1:0] == 2'b00 ##0 s_cfg |=>
		!loop_zero_active && !loop_one_active) else $error("loop none");
	a_loop_zero: assert property (reg_wdata[1:0] == 2'b01 ##0 s_cfg |=>
		loop_zero_active && !loop_one_active) else $error("loop zero");
	a_loop_both: assert property (reg_wdata[1:0] == 2'b10 ##0 s_cfg |=>
		loop_zero_active && loop_one_active) else $error("loop both");
	a_loop_resvd: assert property (reg_wdata[1:0] == 2'b11 ##0 s_cfg |=>
		loop_code_reserved && !loop_zero_active) else $error("loop resvd");
	a_phase_enable: assert property (s_cfg |=>
		phase_acq_enable == $past(reg_wdata[7:4], 2)) else $error("phase");
	a_base_high: assert property (reg_wr && reg_addr == 8'h50 |=>
		synth_a_base_rate_hz[15:8] == $past(reg_wdata)) else $error("base");
	a_mult_low: assert property (reg_wr && reg_addr == 8'h53 |=>
		synth_a_rate_multiplier[7:0] == $past(reg_wdata)) else $error("mult");
	a_num_high: assert property (reg_wr && reg_addr == 8'h54 |=>
		fec_numerator[15:8] == $past(reg_wdata)) else $error("numerator");
	a_den_low: assert property (reg_wr && reg_addr == 8'h57 |=>
		fec_denominator[7:0] == $past(reg_wdata)) else $error("denominator");
	a_read_valid: assert property (reg_rd |=> reg_rvalid)
		else $error("no rvalid");
endmodule // cfg_regs_sva
bind loop_and_synth_a_config_regs cfg_regs_sva chk_i (.sys_clk, .srst,
	.reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rvalid, .loop_zero_active,
	.loop_one_active, .loop_code_reserved, .phase_acq_enable,
	.synth_a_base_rate_hz, .synth_a_rate_multiplier, .fec_numerator,
	.fec_denominator);

// ===== dv/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, reg_rvalid;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, lim, m [10];
	logic z, o, r, bs, fr;
	logic [3:0] pa;
	logic [15:0] b, k, n, d;
	logic [63:0] tbl [7];
	int num_errors = 0, n_compared = 0, seed = 70, t, i;
	always #10 sys_clk = ~sys_clk;
	loop_and_synth_a_config_regs uut (.sys_clk, .srst, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
		.ref_three_monitor_limits(lim), .loop_zero_active(z),
		.loop_one_active(o), .loop_code_reserved(r), .phase_acq_enable(pa),
		.synth_a_base_rate_hz(b), .synth_a_rate_multiplier(k),
		.fec_numerator(n), .fec_denominator(d), .base_rate_supported(bs),
		.synth_a_freq_in_range(fr));
	task chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("FAIL %0t %h %h", $time, s, e);
		end
	endtask
	task wrap_up;
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// register table defaults
	task model_rst;
		for (i = 0; i < 10; i++)
			m[i] = 8'(80'h55f2_9c40_0798_0001_0001 >> (72 - 8 * i));
	endtask
	// strobes stay up so back-to-back calls give one access per cycle
	task acc(input logic w, input logic [7:0] a, dt);
		logic ok;
		logic [7:0] e;
		ok = a >= 8'h4e && a <= 8'h57;
		e = ok ? m[a - 8'h4e] : 8'h00;
		if (a == 8'h4f)
			dt = dt & 8'hf3;
		if (a == 8'h4e)
			dt = dt & 8'h77;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = dt;
		if (w && ok)
			m[a - 8'h4e] = dt;
		@(negedge sys_clk);
		chk(reg_rvalid, !w);
		if (!w)
			chk(reg_rdata, e);
	endtask
	task idle;
		reg_wr = 0;
		reg_rd = 0;
		repeat (3) @(negedge sys_clk);
	endtask
	task sweep;
		for (t = 8'h4c; t < 8'h5a; t++)
			acc(0, 8'(t), 8'h00);
		idle;
	endtask
	// decoded outputs against the model
	task check_all;
		logic [63:0] f;
		f = {m[2], m[3]} * {m[4], m[5]} * 16 * {m[6], m[7]};
		chk(lim, m[0]);
		chk(z, m[1][1:0] == 2'b01 || m[1][1:0] == 2'b10);
		chk(o, m[1][1:0] == 2'b10);
		chk(r, m[1][1:0] == 2'b11);
		chk(pa, m[1][7:4]);
		chk(b, {m[2], m[3]});
		chk(k, {m[4], m[5]});
		chk({n, d}, {m[6], m[7], m[8], m[9]});
		chk(bs, {m[2], m[3]} inside {16'h1388, 16'h186a, 16'h1f40,
			16'h2710, 16'h30d4, 16'h61a8, 16'h9c40});
		chk(fr, {m[8], m[9]} != 0 && f >= 64'd1000000000 * {m[8], m[9]}
			&& f <= 64'd1500000000 * {m[8], m[9]});
	endtask
	initial begin
		#400000;
		num_errors++;
		wrap_up;
	end
	initial begin
		// range edges at 5 kHz, both fec examples, zero denominator
		// range-edge entries keep the ratio at one over one
		// only synth A exists, no shared frequency to program
		tbl = '{64'h9c40_0798_00ff_00ed, 64'h61a8_0c35_41be_3b80,
			64'h1388_30d4_0001_0001, 64'h1388_30d3_0001_0001,
			64'h1388_493e_0001_0001, 64'h1388_493f_0001_0001,
			64'h9c40_0798_0001_0000};
		model_rst;
		repeat (5) @(negedge sys_clk);
		srst = 0;
		idle;
		check_all;
		sweep;
		for (t = 0; t < 4; t++) begin
			acc(1, 8'h4f, {8'($random(seed)) & 8'hfc} | 8'(t));
			idle;
			check_all;
		end
		for (t = 0; t < 7; t++) begin
			for (i = 0; i < 8; i++)
				acc(1, 8'h50 + 8'(i), 8'(tbl[t] >> (56 - 8 * i)));
			idle;
			check_all;
		end
		repeat (60)
			acc(1'($random(seed)), 8'h4c + 8'($unsigned($random(seed)) % 14),
				8'($random(seed)));
		idle;
		check_all;
		sweep;
		// a second reset in mid-run restores every default
		srst = 1;
		repeat (2) @(negedge sys_clk);
		srst = 0;
		model_rst;
		idle;
		check_all;
		sweep;
		wrap_up;
	end
endmodule // testbench

// ===== src/cfg_byte_reg.sv
`timescale 1ns/10ps

module cfg_byte_reg #(
	parameter logic [7:0] reset_value = 8'h00
) (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	output logic      [7:0] q
);

	logic [7:0] value_q;
	logic [7:0] value_d;

	always_comb begin
		value_d = wr_en ? wdata : value_q;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			value_q <= reset_value;
		end else begin
			value_q <= value_d;
		end
	end

	assign q = value_q;

endmodule // cfg_byte_reg

// ===== src/loop_and_synth_a_config_regs.sv
`timescale 1ns/10ps

// Summary of operation
// - two-bit code selects active tracking loops
// - upper nibble enables phase acquisition modules
// - base rate register is hertz directly
// - multiplier register scales the base rate
// - ratio register: numerator high, denominator low
module loop_and_synth_a_config_regs (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	output logic      [7:0]  ref_three_monitor_limits,
	output logic             loop_zero_active,
	output logic             loop_one_active,
	output logic             loop_code_reserved,
	output logic      [3:0]  phase_acq_enable,
	output logic      [15:0] synth_a_base_rate_hz,
	output logic      [15:0] synth_a_rate_multiplier,
	output logic      [15:0] fec_numerator,
	output logic      [15:0] fec_denominator,
	output logic             base_rate_supported,
	output logic             synth_a_freq_in_range
);

	////////////////////////////////////////////////////////////////////////
	// byte storage

	logic [79:0] image;
	logic        in_map;
	logic [7:0]  byte_index;

	assign in_map     = (reg_addr >= loop_synth_cfg_pkg::addr_first) &&
	                    (reg_addr <= loop_synth_cfg_pkg::addr_last);
	assign byte_index = reg_addr - loop_synth_cfg_pkg::addr_first;

	// writes to unmapped addresses are dropped; reserved bits are stored
	// as written since software is expected to restore them itself
	genvar gi;
	generate
		for (gi = 0; gi < loop_synth_cfg_pkg::num_bytes; gi++) begin : g_byte
			localparam int lane = loop_synth_cfg_pkg::num_bytes - 1 - gi;
			cfg_byte_reg #(
				.reset_value (loop_synth_cfg_pkg::rst_image[lane*8 +: 8])
			) u_byte (
				.sys_clk (sys_clk),
				.srst    (srst),
				.wr_en   (reg_wr && in_map && (byte_index == 8'(gi))),
				.wdata   (reg_wdata),
				.q       (image[lane*8 +: 8])
			);
		end
	endgenerate

	logic [7:0]  loop_cfg;
	logic [31:0] ratio;

	assign ref_three_monitor_limits = image[79:72];
	assign loop_cfg                 = image[71:64];
	// base rate in hertz
	// direct hertz value
	assign synth_a_base_rate_hz     = image[63:48];
	assign synth_a_rate_multiplier  = image[47:32];
	assign ratio                    = image[31:0];
	assign fec_numerator   = ratio[loop_synth_cfg_pkg::fec_num_lsb +: 16];
	assign fec_denominator = ratio[loop_synth_cfg_pkg::fec_den_lsb +: 16];

	////////////////////////////////////////////////////////////////////////
	// read port

	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rvalid_q;
	logic       rvalid_d;

	always_comb begin
		rdata_d  = rdata_q;
		rvalid_d = reg_rd;
		if (reg_rd) begin
			rdata_d = 8'h00;
			for (int i = 0; i < loop_synth_cfg_pkg::num_bytes; i++) begin
				if (in_map && (byte_index == 8'(i))) begin
					rdata_d = image[(loop_synth_cfg_pkg::num_bytes-1-i)*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;

	////////////////////////////////////////////////////////////////////////
	// loop and phase acquisition controls

	loop_synth_cfg_pkg::loop_sel_type loop_sel;
	logic loop0_d;
	logic loop1_d;
	logic resv_d;
	logic loop0_q;
	logic loop1_q;
	logic resv_q;
	logic [3:0] pacq_d;
	logic [3:0] pacq_q;

	assign loop_sel = loop_synth_cfg_pkg::loop_sel_type'(
		loop_cfg[loop_synth_cfg_pkg::loop_sel_lsb +:
		         loop_synth_cfg_pkg::loop_sel_width]);

	always_comb begin
		loop0_d = 1'b0;
		loop1_d = 1'b0;
		resv_d  = 1'b0;
		unique case (loop_sel)
			loop_synth_cfg_pkg::loops_none: begin
			end
			loop_synth_cfg_pkg::loops_zero: begin
				loop0_d = 1'b1;
			end
			loop_synth_cfg_pkg::loops_zero_one: begin
				loop0_d = 1'b1;
				loop1_d = 1'b1;
			end
			// reserved code keeps both loops off rather than guessing
			loop_synth_cfg_pkg::loops_reserved: begin
				resv_d = 1'b1;
			end
		endcase
		pacq_d = loop_cfg[loop_synth_cfg_pkg::phase_acq_lsb +:
		                  loop_synth_cfg_pkg::phase_acq_width];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			loop0_q <= 1'b0;
			loop1_q <= 1'b0;
			resv_q  <= 1'b0;
			pacq_q  <= 4'h0;
		end else begin
			loop0_q <= loop0_d;
			loop1_q <= loop1_d;
			resv_q  <= resv_d;
			pacq_q  <= pacq_d;
		end
	end

	assign loop_zero_active   = loop0_q;
	assign loop_one_active    = loop1_q;
	assign loop_code_reserved = resv_q;
	assign phase_acq_enable   = pacq_q;

	////////////////////////////////////////////////////////////////////////
	// programming sanity status

	logic [63:0] synth_num;
	logic [63:0] lim_lo;
	logic [63:0] lim_hi;
	logic        base_ok_d;
	logic        base_ok_q;
	logic        range_ok_d;
	logic        range_ok_q;

	assign synth_num = 64'(synth_a_base_rate_hz) *
	                   64'(synth_a_rate_multiplier) *
	                   loop_synth_cfg_pkg::synth_scale *
	                   64'(fec_numerator);
	assign lim_lo = 64'(fec_denominator) * loop_synth_cfg_pkg::synth_min_hz;
	assign lim_hi = 64'(fec_denominator) * loop_synth_cfg_pkg::synth_max_hz;

	always_comb begin
		unique case (synth_a_base_rate_hz)
			loop_synth_cfg_pkg::base_5k,
			loop_synth_cfg_pkg::base_6k25,
			loop_synth_cfg_pkg::base_8k,
			loop_synth_cfg_pkg::base_10k,
			loop_synth_cfg_pkg::base_12k5,
			loop_synth_cfg_pkg::base_25k,
			loop_synth_cfg_pkg::base_40k: begin
				base_ok_d = 1'b1;
			end
			default: begin
				base_ok_d = 1'b0;
			end
		endcase
		range_ok_d = (fec_denominator != 16'h0000) &&
		             (synth_num >= lim_lo) && (synth_num <= lim_hi);
	end

	// status only; nothing here blocks a write, software stays in charge
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			base_ok_q  <= 1'b0;
			range_ok_q <= 1'b0;
		end else begin
			base_ok_q  <= base_ok_d;
			range_ok_q <= range_ok_d;
		end
	end

	assign base_rate_supported   = base_ok_q;
	assign synth_a_freq_in_range = range_ok_q;

endmodule // loop_and_synth_a_config_regs

// ===== src/loop_synth_cfg_pkg.sv
package loop_synth_cfg_pkg;

	// byte addresses of the host register map
	localparam logic [7:0] addr_ref_three_monitor_limits = 8'h4e;
	localparam logic [7:0] addr_loop_activation_config   = 8'h4f;
	localparam logic [7:0] addr_synth_a_base_rate        = 8'h50;
	localparam logic [7:0] addr_synth_a_rate_multiplier  = 8'h52;
	localparam logic [7:0] addr_synth_a_fec_ratio        = 8'h54;
	localparam logic [7:0] addr_first                    = 8'h4e;
	localparam logic [7:0] addr_last                     = 8'h57;
	localparam int         num_bytes                     = 10;

	// reset values
	localparam logic [7:0]  rst_ref_three_monitor_limits = 8'h55;
	localparam logic [7:0]  rst_loop_activation_config   = 8'hf2;
	localparam logic [15:0] rst_synth_a_base_rate        = 16'h9c40;
	localparam logic [15:0] rst_synth_a_rate_multiplier  = 16'h0798;
	localparam logic [31:0] rst_synth_a_fec_ratio        = 32'h0001_0001;

	// reset image, byte at addr_first in the top lane
	localparam logic [79:0] rst_image = {
		rst_ref_three_monitor_limits,
		rst_loop_activation_config,
		rst_synth_a_base_rate,
		rst_synth_a_rate_multiplier,
		rst_synth_a_fec_ratio
	};

	// field positions
	localparam int loop_sel_lsb      = 0;
	localparam int loop_sel_width    = 2;
	localparam int phase_acq_lsb     = 4;
	localparam int phase_acq_width   = 4;
	localparam int fec_num_lsb       = 16;
	localparam int fec_den_lsb       = 0;

	// loop activation codes
	typedef enum logic [1:0] {
		loops_none     = 2'b00,
		loops_zero     = 2'b01,
		loops_zero_one = 2'b10,
		loops_reserved = 2'b11
	} loop_sel_type;

	// supported base rates in hertz
	localparam logic [15:0] base_5k    = 16'h1388;
	localparam logic [15:0] base_6k25  = 16'h186a;
	localparam logic [15:0] base_8k    = 16'h1f40;
	localparam logic [15:0] base_10k   = 16'h2710;
	localparam logic [15:0] base_12k5  = 16'h30d4;
	localparam logic [15:0] base_25k   = 16'h61a8;
	localparam logic [15:0] base_40k   = 16'h9c40;

	// synthesizer scaling and range
	localparam logic [63:0] synth_scale   = 64'h10;
	localparam logic [63:0] synth_min_hz  = 64'h0000_0000_3b9a_ca00;
	localparam logic [63:0] synth_max_hz  = 64'h0000_0000_5968_2f00;

endpackage
